/* hdl/msss_pkg.sv */
package msss_pkg;
	// =====================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_THR = 8'h08;
	localparam logic [7:0] ADDR_BEMF = 8'h0C;
	// =====================================
	// Control word fields
	localparam int CTRL_JITTER = 0;
	localparam int CTRL_STAB_LSB = 1;
	localparam int CTRL_FULLDUTY = 4;
	localparam int CTRL_ARM_LSB = 5;
	localparam int CTRL_SMP_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Threshold word fields
	localparam int THR_WORK_LSB = 0;
	localparam int THR_NV_LSB = 4;
	localparam logic [3:0] THR_RST = 4'h0;
	localparam logic [3:0] NV_THR_RST = 4'h0;
	// =====================================
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int UV_TIME_S = 15;
	localparam logic [31:0] UV_CYCLES = 32'(64'(UV_TIME_S) * 64'd1000000 * 64'(CLK_MHZ));
	localparam int SAMPLE_US [16] = '{88, 132, 175, 219, 307, 395, 482, 570,
		658, 746, 833, 921, 1009, 1097, 1184, 1272};
	localparam int STAB_US [8] = '{1000, 2000, 4000, 8000, 16000, 32000, 64000, 128000};
	localparam int AVG_DEPTH = 4;
	// =====================================
	// Coil current modes
	typedef enum logic [1:0] {
		COIL_HOLD = 2'h0,
		COIL_RUN = 2'h1,
		COIL_FREEZE = 2'h2,
		COIL_OFF = 2'h3
	} msss_coil_t;
	// Supervisor states
	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_RUN = 4'h2,
		ST_STAB = 4'h4,
		ST_SHUT = 4'h8
	} msss_state_t;
endpackage

/* hdl/msss_tmr_if.sv */
`timescale 1ns/100ps
interface msss_tmr_if;
	logic start;
	logic clr;
	logic [31:0] load;
	logic busy;
	logic done;
	modport ctl (output start, output clr, output load, input busy, input done);
	modport tmr (input start, input clr, input load, output busy, output done);
endinterface // msss_tmr_if

/* hdl/msss_delay_timer.sv */
`timescale 1ns/100ps
module msss_delay_timer (
	input wire logic clock,
	input wire logic nrst,
	msss_tmr_if.tmr t
);
	typedef struct packed {
		logic [31:0] cnt;
		logic busy;
		logic done;
	} msss_tmr_st_t;
	msss_tmr_st_t q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (t.clr) begin
			d.busy = 1'b0;
		end else if (t.start) begin
			// A zero load still waits one cycle
			d.cnt = (t.load == 32'h0000_0000) ? 32'h0000_0001 : t.load;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (q.cnt == 32'h0000_0001) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign t.busy = q.busy;
	assign t.done = q.done;
endmodule // msss_delay_timer

/* hdl/msss_top.sv */
// Functional notes
// [R1] - Jitter bit selects fixed or jittered PWM
// [R2] - Motion start switches hold to run current
// [R3] - Freeze currents, stabilise, then hold at target
// [R4] - Stabilisation time has eight programmable values
// [R5] - Bridge voltage drop opens that bridge
// [R6] - Full duty longer than 1/Vmin: open coil (code: timed only in ST_HOLD)
// [R7] - Thermal, long undervoltage or defect: shutdown
// [R8] - Shutdown: bridges off, target takes actual (code: copy only when autarkic is low)
// [R9] - Leave shutdown on status read, causes gone
// [R10] - Bus lost in shutdown: sleep at once
// [R11] - Master limits repeated failing status reads
// [R12] - Averaged back-emf below threshold sets stall
// [R13] - Evaluate stall only at maximum velocity
// [R14] - Stall: hard stop, step-loss, stall, copy position
// [R15] - Two-phase stall: second phase after stabilisation
// [R16] - Full read clears step-loss and stall flags
// [R17] - Short read clears only step-loss
// [R18] - Four-bit threshold, zero disables, command writable
// [R19] - Reset loads nonvolatile threshold into working
// [R20] - Zero crossing starts sample delay, 88-1272 us
// [R21] - Arm after ramp plus extra full steps
// [R22] - Three-bit arm code equals full steps
// [R23] - Bit enables stall check at full duty
// [R24] - Faults clear only after read and recovery
// [R25] - All timers on system clock, reset cleared
`timescale 1ns/100ps
module msss_top #(
	parameter int CYC_PER_US = msss_pkg::CLK_MHZ,
	parameter logic [31:0] UV_CYCLES = msss_pkg::UV_CYCLES,
	parameter logic [3:0] NV_THR_RESET = msss_pkg::NV_THR_RST
) (
	input wire logic clock,
	input wire logic nrst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Analog comparators, asynchronous
	input wire logic thermalShutdownIn,
	input wire logic undervoltageLevelTwo,
	input wire logic bridgeDropX,
	input wire logic bridgeDropY,
	input wire logic fullDutyX,
	input wire logic fullDutyY,
	input wire logic zeroCross,
	// Back-emf converter result, system clock domain
	input wire logic [7:0] bemfValue,
	// Position controller, system clock domain
	input wire logic motionStart,
	input wire logic running,
	input wire logic accelDone,
	input wire logic atMaxVelocity,
	input wire logic decelDone,
	input wire logic fullStep,
	input wire logic twoPhaseMove,
	input wire logic autarkic,
	input wire logic [31:0] minVelPeriod,
	// Protocol handler, system clock domain
	input wire logic shortStatusReadCmd,
	input wire logic fullStatusReadCmd,
	input wire logic stallParamWriteCmd,
	input wire logic nonvolatileParamWriteCmd,
	input wire logic [3:0] cmdThreshold,
	input wire logic linLost,
	// Outputs
	output logic pwmJitterEnable,
	output logic [1:0] coilMode,
	output logic bridgeEnX,
	output logic bridgeEnY,
	output logic newOrderAllowed,
	output logic hardStopReq,
	output logic copyCounterToActual,
	output logic copyActualToTarget,
	output logic loadHoldAtTarget,
	output logic startSecondPhase,
	output logic sleepReq,
	output logic [8:0] statusFlags
);
	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic zcPrev;
		logic wrAct;
		logic [7:0] wrAddr;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [3:0] thr;
		logic [3:0] nvThr;
		logic porDone;
		msss_pkg::msss_state_t state;
		logic [1:0] coil;
		logic enX;
		logic enY;
		logic [3:0][7:0] hist;
		logic [7:0] avg;
		logic cmpPend;
		logic [2:0] stepCnt;
		logic stepLoss;
		logic stall;
		logic absolute_stall_flag;
		logic elDef;
		logic offX;
		logic offY;
		logic uvLong;
		logic tsd;
		logic pendSecond;
		logic uvArm;
		logic openArm;
		logic hardStop;
		logic copyCnt;
		logic copyTag;
		logic loadHold;
		logic startSecond;
		logic sleep;
		logic [8:0] status;
	} msss_top_st_t;
	msss_top_st_t q, d;

	msss_tmr_if smpT ();
	msss_tmr_if stabT ();
	msss_tmr_if uvT ();
	msss_tmr_if openT ();

	// =====================================
	// Timers
	msss_delay_timer uSmp (.clock(clock), .nrst(nrst), .t(smpT.tmr));
	msss_delay_timer uStab (.clock(clock), .nrst(nrst), .t(stabT.tmr));
	msss_delay_timer uUv (.clock(clock), .nrst(nrst), .t(uvT.tmr));
	msss_delay_timer uOpen (.clock(clock), .nrst(nrst), .t(openT.tmr));

	logic tsdS, uvS, dropXS, dropYS, fdS, zcS;
	logic readAny, cause, armed, evalOk, stallHit;
	logic [3:0] smpCode;
	logic [2:0] stabCode, armCode;
	logic [9:0] sumNew;

	always_comb begin
		tsdS = q.sync2[6];
		uvS = q.sync2[5];
		dropXS = q.sync2[4];
		dropYS = q.sync2[3];
		fdS = q.sync2[2] | q.sync2[1];
		zcS = q.sync2[0];
		readAny = shortStatusReadCmd | fullStatusReadCmd;
		smpCode = q.ctrl[msss_pkg::CTRL_SMP_LSB +: 4];
		stabCode = q.ctrl[msss_pkg::CTRL_STAB_LSB +: 3];
		armCode = q.ctrl[msss_pkg::CTRL_ARM_LSB +: 3];
		cause = tsdS | q.uvLong | q.elDef; // [R7]
		armed = running & accelDone & (q.stepCnt == armCode); // [R21] [R22]
		evalOk = armed & atMaxVelocity & (q.thr != 4'h0) // [R13] [R18]
			& (q.ctrl[msss_pkg::CTRL_FULLDUTY] | ~fdS); // [R23]
		stallHit = q.cmpPend & evalOk & (q.state == msss_pkg::ST_RUN)
			& (q.avg < {q.thr, 4'h0}); // [R12]
		sumNew = 10'(bemfValue) + 10'(q.hist[0]) + 10'(q.hist[1]) + 10'(q.hist[2]);

		// Timer controls
		smpT.start = zcS & ~q.zcPrev; // [R20]
		smpT.clr = 1'b0;
		smpT.load = 32'(msss_pkg::SAMPLE_US[smpCode] * CYC_PER_US); // [R20] [R25]
		stabT.clr = 1'b0;
		stabT.load = 32'(msss_pkg::STAB_US[stabCode] * CYC_PER_US); // [R4] [R25]
		stabT.start = 1'b0;
		uvT.clr = ~uvS;
		uvT.start = uvS & ~q.uvArm;
		uvT.load = UV_CYCLES; // [R25]
		openT.clr = ~(fdS & (q.state == msss_pkg::ST_HOLD)); // [R6]
		openT.start = fdS & (q.state == msss_pkg::ST_HOLD) & ~q.openArm;
		openT.load = minVelPeriod; // [R6]

		d = q;
		d.hardStop = 1'b0;
		d.copyCnt = 1'b0;
		d.copyTag = 1'b0;
		d.loadHold = 1'b0;
		d.startSecond = 1'b0;
		d.sleep = 1'b0;
		d.cmpPend = 1'b0;
		d.sync1 = {thermalShutdownIn, undervoltageLevelTwo, bridgeDropX, bridgeDropY,
			fullDutyX, fullDutyY, zeroCross};
		d.sync2 = q.sync1;
		d.zcPrev = zcS;
		d.uvArm = uvS;
		d.openArm = ~openT.clr;

		// =====================================
		// Bus slave: zero wait states, read data registered in address phase
		d.wrAct = hsel & htrans[1] & hready & hwrite;
		d.wrAddr = haddr[7:0];
		if (hsel & htrans[1] & hready & ~hwrite) begin
			case (haddr[7:0])
				msss_pkg::ADDR_CTRL: d.rdata = q.ctrl;
				msss_pkg::ADDR_STATUS: d.rdata = {19'h0, q.state, q.status};
				msss_pkg::ADDR_THR: d.rdata = {24'h0, q.nvThr, q.thr};
				msss_pkg::ADDR_BEMF: d.rdata = {24'h0, q.avg};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		if (q.wrAct) begin
			case (q.wrAddr)
				msss_pkg::ADDR_CTRL: d.ctrl = hwdata;
				msss_pkg::ADDR_THR: begin
					d.thr = hwdata[msss_pkg::THR_WORK_LSB +: 4];
					d.nvThr = hwdata[msss_pkg::THR_NV_LSB +: 4];
				end
				default: d.wrAddr = q.wrAddr;
			endcase
		end
		// Commands from the bus handler win over a simultaneous register write
		if (stallParamWriteCmd) begin
			d.thr = cmdThreshold; // [R18]
		end
		if (nonvolatileParamWriteCmd) begin
			d.nvThr = cmdThreshold; // [R19]
		end
		// First cycle after reset release copies the stored threshold
		if (!q.porDone) begin
			d.thr = q.nvThr; // [R19]
			d.porDone = 1'b1;
		end

		// =====================================
		// Fault flags: a read clears only once the condition is gone, set wins
		if (readAny & ~tsdS) begin
			d.tsd = 1'b0; // [R24]
		end
		if (readAny & ~uvS) begin
			d.uvLong = 1'b0; // [R24]
		end
		if (readAny & ~dropXS & ~dropYS & ~fdS) begin
			d.elDef = 1'b0; // [R24]
			d.offX = 1'b0;
			d.offY = 1'b0;
		end
		if (tsdS) begin
			d.tsd = 1'b1;
		end
		if (uvT.done) begin
			d.uvLong = 1'b1; // [R7]
		end
		if (dropXS) begin
			d.offX = 1'b1; // [R5]
			d.elDef = 1'b1;
		end
		if (dropYS) begin
			d.offY = 1'b1; // [R5]
			d.elDef = 1'b1;
		end
		if (openT.done) begin
			d.elDef = 1'b1; // [R6]
		end

		// =====================================
		// Motion detection
		if (!running || !accelDone) begin
			d.stepCnt = 3'h0;
		end else if (fullStep && q.stepCnt != armCode) begin
			d.stepCnt = q.stepCnt + 3'h1; // [R21]
		end
		if (smpT.done) begin
			d.hist = {q.hist[2:0], bemfValue}; // [R20]
			d.avg = sumNew[9:2]; // [R12]
			d.cmpPend = 1'b1;
		end
		// Step-loss clears on any read, stall flags only on a full read
		if (readAny) begin
			d.stepLoss = 1'b0; // [R17]
		end
		if (fullStatusReadCmd) begin
			d.stall = 1'b0; // [R16]
			d.absolute_stall_flag = 1'b0;
		end
		if (stallHit) begin
			d.stall = 1'b1; // [R14]
			d.absolute_stall_flag = 1'b1;
			d.stepLoss = 1'b1;
			d.hardStop = 1'b1;
			d.copyCnt = 1'b1;
			if (twoPhaseMove) begin
				d.pendSecond = 1'b1; // [R15]
			end
		end

		// =====================================
		// Coil current sequencing and shutdown
		case (q.state)
			msss_pkg::ST_HOLD: begin
				if (motionStart) begin
					d.state = msss_pkg::ST_RUN; // [R2]
					d.coil = msss_pkg::COIL_RUN;
				end
			end
			msss_pkg::ST_RUN: begin
				if (decelDone | stallHit) begin
					d.state = msss_pkg::ST_STAB; // [R3]
					d.coil = msss_pkg::COIL_FREEZE;
					stabT.start = 1'b1;
				end
			end
			msss_pkg::ST_STAB: begin
				if (stabT.done) begin
					d.state = msss_pkg::ST_HOLD; // [R3]
					d.coil = msss_pkg::COIL_HOLD;
					d.loadHold = 1'b1;
					if (q.pendSecond) begin
						d.startSecond = 1'b1; // [R15]
						d.pendSecond = 1'b0;
					end
				end
			end
			msss_pkg::ST_SHUT: begin
				if (linLost) begin
					d.sleep = 1'b1; // [R10]
				end
				if (readAny & ~cause) begin
					d.state = msss_pkg::ST_HOLD; // [R9]
					d.coil = msss_pkg::COIL_HOLD;
				end
			end
			default: begin
				d.state = msss_pkg::ST_HOLD;
				d.coil = msss_pkg::COIL_HOLD;
			end
		endcase
		if (cause && q.state != msss_pkg::ST_SHUT) begin
			d.state = msss_pkg::ST_SHUT; // [R7]
			d.coil = msss_pkg::COIL_OFF;
			d.copyTag = ~autarkic; // [R8]
			d.pendSecond = 1'b0;
			stabT.clr = 1'b1;
		end
		// An opened bridge stays off until a read clears its flag; a shutdown exit waits for that
		d.enX = (d.state != msss_pkg::ST_SHUT) & ~d.offX; // [R5] [R8]
		d.enY = (d.state != msss_pkg::ST_SHUT) & ~d.offY;
		d.status = {d.state == msss_pkg::ST_SHUT, d.offY, d.offX, d.uvLong, d.tsd,
			d.elDef, d.absolute_stall_flag, d.stall, d.stepLoss};
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.ctrl <= msss_pkg::CTRL_RST;
			q.thr <= msss_pkg::THR_RST;
			q.nvThr <= NV_THR_RESET;
			q.state <= msss_pkg::ST_HOLD;
			q.coil <= msss_pkg::COIL_HOLD;
			q.enX <= 1'b1;
			q.enY <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// =====================================
	// Outputs
	assign hrdata = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pwmJitterEnable = q.ctrl[msss_pkg::CTRL_JITTER]; // [R1]
	assign coilMode = q.coil;
	assign bridgeEnX = q.enX;
	assign bridgeEnY = q.enY;
	assign newOrderAllowed = (q.state == msss_pkg::ST_HOLD); // [R3] [R9]
	assign hardStopReq = q.hardStop;
	assign copyCounterToActual = q.copyCnt;
	assign copyActualToTarget = q.copyTag;
	assign loadHoldAtTarget = q.loadHold;
	assign startSecondPhase = q.startSecond;
	assign sleepReq = q.sleep;
	assign statusFlags = q.status;
endmodule // msss_top

/* test/msss_coil_model.sv */
`timescale 1ns/100ps
// =====================================
// Coil pair behind the two bridges
module msss_coil_model (
	input wire logic bridgeEnX,
	input wire logic bridgeEnY,
	input wire logic [1:0] coilMode,
	input wire logic [1:0] shorted,
	input wire logic [1:0] open,
	output logic dropX,
	output logic dropY,
	output logic fullX,
	output logic fullY
);
	logic drive;
	assign drive = coilMode != msss_pkg::COIL_OFF;
	// A short only shows as a drop while the bridge really conducts
	assign dropX = shorted[0] && bridgeEnX && drive;
	assign dropY = shorted[1] && bridgeEnY && drive;
	// An open coil saturates the regulator at full duty
	assign fullX = open[0] && bridgeEnX && drive;
	assign fullY = open[1] && bridgeEnY && drive;
endmodule // msss_coil_model

/* test/msss_props.sv */
`timescale 1ns/100ps
// =====================================
// Port checker
module msss_props (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic motionStart,
	input wire logic decelDone,
	input wire logic linLost,
	input wire logic autarkic,
	input wire logic shortStatusReadCmd,
	input wire logic fullStatusReadCmd,
	input wire logic [1:0] coilMode,
	input wire logic bridgeEnX,
	input wire logic bridgeEnY,
	input wire logic newOrderAllowed,
	input wire logic hardStopReq,
	input wire logic copyCounterToActual,
	input wire logic copyActualToTarget,
	input wire logic sleepReq,
	input wire logic [8:0] statusFlags
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_bus_okay: assert property (hresp == 1'b0 && hreadyout) else $error("bus answer not okay");
	a_start_run: assert property (newOrderAllowed && motionStart |=> coilMode == msss_pkg::COIL_RUN) else $error("no run current");
	a_stop_freeze: assert property (coilMode == msss_pkg::COIL_RUN && decelDone |=> coilMode == msss_pkg::COIL_FREEZE) else $error("no freeze");
	a_freeze_blocks: assert property (coilMode == msss_pkg::COIL_FREEZE |-> !newOrderAllowed) else $error("order during stab");
	a_shut_bridges: assert property (coilMode == msss_pkg::COIL_OFF |-> !bridgeEnX && !bridgeEnY) else $error("bridge drives in shutdown");
	a_shut_copy: assert property ($rose(coilMode == msss_pkg::COIL_OFF) && !$past(autarkic) |-> copyActualToTarget) else $error("no target copy");
	a_lost_sleep: assert property (coilMode == msss_pkg::COIL_OFF && $rose(linLost) |=> sleepReq) else $error("no sleep");
	a_stall_stop: assert property ($rose(hardStopReq) |-> statusFlags[2:0] == 3'h7 && copyCounterToActual) else $error("bad stall stop");
	a_stall_run: assert property ($rose(statusFlags[1]) |-> $past(coilMode) == msss_pkg::COIL_RUN) else $error("stall outside run");
	a_full_clear: assert property (fullStatusReadCmd && coilMode != msss_pkg::COIL_RUN |=> statusFlags[2:0] == 3'h0) else $error("full read kept");
	a_short_keep: assert property (shortStatusReadCmd && coilMode != msss_pkg::COIL_RUN
		|=> !statusFlags[0] && statusFlags[2:1] == $past(statusFlags[2:1])) else $error("short read wrong");
	c_stall: cover property ($rose(hardStopReq));
	c_sleep: cover property (sleepReq);
	c_freeze: cover property ($rose(coilMode == msss_pkg::COIL_FREEZE));
endmodule // msss_props
bind msss_top msss_props u_props (.clock(clock), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
	.motionStart(motionStart), .decelDone(decelDone), .linLost(linLost), .autarkic(autarkic),
	.shortStatusReadCmd(shortStatusReadCmd), .fullStatusReadCmd(fullStatusReadCmd), .coilMode(coilMode),
	.bridgeEnX(bridgeEnX), .bridgeEnY(bridgeEnY), .newOrderAllowed(newOrderAllowed), .hardStopReq(hardStopReq),
	.copyCounterToActual(copyCounterToActual), .copyActualToTarget(copyActualToTarget), .sleepReq(sleepReq),
	.statusFlags(statusFlags));

/* test/msss_top_tb.sv */
`timescale 1ns/100ps
module msss_top_tb;
	// =====================================
	// Stimulus and observed signals
	localparam int SRD = 0, FRD = 1, PRM = 2, NVP = 3, GO = 4, DEC = 5, LOST = 6, STEP = 7;
	localparam logic [8:0] FLAG [4] = '{9'h110, 9'h120, 9'h148, 9'h108};
	logic clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, coilMode;
	logic [7:0] pl = 8'h00;
	logic autarkic = 1'b0;
	logic [3:0] cause = 4'h0, cmdThreshold = 4'h0;
	logic zeroCross = 1'b0, running = 1'b0, accelDone = 1'b0, atMaxVelocity = 1'b0, twoPhaseMove = 1'b0;
	logic [7:0] bemfValue = 8'h0;
	logic hreadyout, hresp, bridgeDropX, bridgeDropY, fullDutyX, fullDutyY, pwmJitterEnable;
	logic bridgeEnX, bridgeEnY, newOrderAllowed, hardStopReq, copyCounterToActual, copyActualToTarget;
	logic loadHoldAtTarget, startSecondPhase, sleepReq;
	logic [8:0] statusFlags;
	int nErrors = 0, checked = 0, cycles = 0;
	// Short counts keep the run brief: one cycle per microsecond
	msss_top #(.CYC_PER_US(1), .UV_CYCLES(32'h32), .NV_THR_RESET(4'h3)) dut (.clock, .nrst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.thermalShutdownIn(cause[0]), .undervoltageLevelTwo(cause[1]), .bridgeDropX, .bridgeDropY, .fullDutyX,
		.fullDutyY, .zeroCross, .bemfValue, .motionStart(pl[GO]), .running, .accelDone, .atMaxVelocity,
		.decelDone(pl[DEC]), .fullStep(pl[STEP]), .twoPhaseMove, .autarkic, .minVelPeriod(32'h1E),
		.shortStatusReadCmd(pl[SRD]), .fullStatusReadCmd(pl[FRD]), .stallParamWriteCmd(pl[PRM]),
		.nonvolatileParamWriteCmd(pl[NVP]), .cmdThreshold, .linLost(pl[LOST]), .pwmJitterEnable, .coilMode,
		.bridgeEnX, .bridgeEnY, .newOrderAllowed, .hardStopReq, .copyCounterToActual, .copyActualToTarget,
		.loadHoldAtTarget, .startSecondPhase, .sleepReq, .statusFlags);
	msss_coil_model coils (.bridgeEnX(bridgeEnX), .bridgeEnY(bridgeEnY), .coilMode(coilMode),
		.shorted({1'b0, cause[2]}), .open({cause[3], 1'b0}), .dropX(bridgeDropX), .dropY(bridgeDropY),
		.fullX(fullDutyX), .fullY(fullDutyY));
	// =====================================
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic pulse(input int k);
		@(posedge clock);
		pl[k] <= 1'b1;
		@(posedge clock);
		pl <= 8'h00;
		#1;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		q = hrdata;
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// =====================================
	// Clock, watchdog and sequence
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 10000) begin
			nErrors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		tick(2);
		chk("idle outputs", {bridgeEnX, bridgeEnY, newOrderAllowed, coilMode, statusFlags}, 14'h3800);
		bus(0, msss_pkg::ADDR_THR, 32'h0, rd);
		chk("thr at reset", rd[7:0], 8'h33);
		cmdThreshold <= 4'h5;
		pulse(NVP);
		cmdThreshold <= 4'h0;
		pulse(PRM);
		bus(0, msss_pkg::ADDR_THR, 32'h0, rd);
		chk("thr after cmds", rd[7:0], 8'h50);
		bus(1, msss_pkg::ADDR_CTRL, 32'h1, rd);
		chk("jitter on", pwmJitterEnable, 1'b1);
		bus(1, msss_pkg::ADDR_CTRL, 32'h0, rd);
		chk("jitter off", pwmJitterEnable, 1'b0);
		bus(0, 8'h10, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		$display("test registers done");
		running <= 1'b1;
		accelDone <= 1'b1;
		atMaxVelocity <= 1'b1;
		pulse(GO);
		chk("run mode", {coilMode, newOrderAllowed}, 3'h2);
		zeroCross <= 1'b1;
		tick(150);
		chk("no stall at thr 0", statusFlags[1], 1'b0);
		zeroCross <= 1'b0;
		pulse(DEC);
		chk("freeze", coilMode, msss_pkg::COIL_FREEZE);
		tick(990);
		chk("still frozen", {coilMode, newOrderAllowed}, 3'h4);
		while (loadHoldAtTarget !== 1'b1) tick(1);
		chk("hold after stab", {coilMode, newOrderAllowed}, 3'h1);
		$display("test motion stop done");
		bus(1, msss_pkg::ADDR_CTRL, 32'h42, rd);
		cmdThreshold <= 4'h1;
		pulse(PRM);
		twoPhaseMove <= 1'b1;
		pulse(STEP);
		pulse(GO);
		zeroCross <= 1'b1;
		tick(80);
		chk("sample delay", statusFlags[1], 1'b0);
		tick(40);
		chk("arm steps short", statusFlags[1], 1'b0);
		zeroCross <= 1'b0;
		pulse(STEP);
		zeroCross <= 1'b1;
		while (hardStopReq !== 1'b1) tick(1);
		chk("stall flags", {statusFlags[2:0], copyCounterToActual}, 4'hF);
		zeroCross <= 1'b0;
		running <= 1'b0;
		tick(1500);
		chk("longer stab", coilMode, msss_pkg::COIL_FREEZE);
		while (startSecondPhase !== 1'b1) tick(1);
		chk("second phase", loadHoldAtTarget, 1'b1);
		pulse(SRD);
		chk("short read", statusFlags[2:0], 3'h6);
		pulse(FRD);
		chk("full read", statusFlags[2:0], 3'h0);
		twoPhaseMove <= 1'b0;
		$display("test stall done");
		for (int k = 0; k < 4; k++) begin
			cause[k] <= 1'b1;
			autarkic <= (k == 3);
			if (k == 1) begin
				tick(40);
				chk("uv too short", coilMode, msss_pkg::COIL_HOLD);
			end
			while (coilMode !== msss_pkg::COIL_OFF) tick(1);
			chk("target copy", copyActualToTarget, 32'(k < 3));
			chk("shut mode", {coilMode, bridgeEnX, bridgeEnY}, 4'hC);
			chk("cause flags", statusFlags & FLAG[k], FLAG[k]);
			pulse(SRD);
			chk("stays shut", coilMode, msss_pkg::COIL_OFF);
			pulse(LOST);
			chk("sleep", sleepReq, 1'b1);
			cause[k] <= 1'b0;
			tick(4);
			// First read clears latched causes, the second one may leave shutdown
			pulse(SRD);
			pulse(FRD);
			chk("shut exit", {coilMode, bridgeEnX, bridgeEnY}, 4'h3);
		end
		autarkic <= 1'b0;
		$display("test shutdown done");
		tally_and_finish();
	end
endmodule // msss_top_tb
